// *** wrs_pkg.sv ***
package wrs_pkg;

   // Timing is kept in half CPU periods; the clock cycle holds two of them
   localparam int HALF_PER_CYCLE = 2;
   localparam int ASSERT_MIN_TCL = 4;
   localparam int ASSERT_MIN_CYC = (ASSERT_MIN_TCL + HALF_PER_CYCLE - 1) / HALF_PER_CYCLE;
   localparam int CANCEL_MAX_TCL = 12;
   localparam int CANCEL_MAX_CYC = CANCEL_MAX_TCL / HALF_PER_CYCLE;
   localparam int SEQ_TCL = 1024;
   localparam int SEQ_CYC = SEQ_TCL / HALF_PER_CYCLE;
   localparam int SAMPLE_DLY_TCL = 8;
   localparam int SAMPLE_DLY_CYC = SAMPLE_DLY_TCL / HALF_PER_CYCLE;
   localparam int TRANSP_MIN_TCL = 3;
   localparam int TRANSP_MAX_TCL = 4;
   localparam int TRANSP_CYC = (TRANSP_MIN_TCL + HALF_PER_CYCLE - 1) / HALF_PER_CYCLE;

   localparam int CNT_W = 10;
   localparam logic [1:0] ASSERT_LAST = 2'(ASSERT_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] CANCEL_LAST = CNT_W'(CANCEL_MAX_CYC - 1);
   localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYC - 1);
   localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_DLY_CYC - 1);
   localparam logic [1:0] TRANSP_LAST = 2'(TRANSP_CYC - 1);

   // Register map, word index on the plain register port
   localparam logic [3:0] OFS_SYSCFG = 4'h0;
   localparam logic [3:0] OFS_CMD = 4'h1;
   localparam logic [3:0] OFS_STATUS = 4'h2;
   localparam logic [3:0] OFS_CONFIG = 4'h3;

   localparam int BIDIR_EN_BIT = 3;
   localparam int CMD_SOFT_RESET_BIT = 0;
   localparam int CMD_END_INIT_BIT = 1;
   localparam int STATUS_INIT_PENDING_BIT = 4;

   localparam logic [15:0] SYSCFG_RST = 16'h0000;
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   localparam logic [15:0] SOFT_LATCHED_MASK = 16'h1F00;
   localparam logic [15:0] SOFT_CLEARED_MASK = 16'h00FC;
   localparam logic [23:0] FETCH_START_ADDR = 24'h00_0000;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'b000_0001,
      ST_DETECT = 7'b000_0010,
      ST_SEQ    = 7'b000_0100,
      ST_SAMPLE = 7'b000_1000,
      ST_EXTEND = 7'b001_0000,
      ST_ASYNC  = 7'b010_0000,
      ST_FLASH  = 7'b100_0000
   } wrs_state_t;

   typedef struct packed {
      logic async_rst;
      logic long_rst;
      logic short_rst;
      logic soft_rst;
   } wrs_flags_t;

   localparam wrs_flags_t FLAGS_RST = '{default: 1'b0};

endpackage

// *** wrs_sequencer.sv ***
`timescale 1ns/1ps
module wrs_sequencer
   import wrs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   input wire logic RESET_IN_N_I,
   output logic RESET_IN_N_O,
   output logic RESET_IN_N_OE_N_O,
   input wire logic FILTERED_RESET_IN_I,
   input wire logic RESET_MODE_SENSE_PIN_I,
   output logic RESET_MODE_PULLDOWN_O,
   input wire logic EXTERNAL_BOOT_SELECT_I,
   input wire logic WATCHDOG_RESET_I,
   input wire logic FLASH_INIT_DONE_I,
   output logic FLASH_INIT_REQ_O,
   output logic FLASH_ONLY_RESET_O,
   input wire logic [15:0] PORT0_I,
   output logic [15:0] CONFIG_O,
   output logic CLOCK_OPTION_PINS_TRANSPARENT_O,
   output logic RESET_OUT_N_O,
   output logic CPU_RESET_O,
   output logic IO_TRISTATE_O,
   output logic BUS_ABORT_O,
   output logic HOLD_CANCEL_O,
   output logic STROBES_IDLE_O,
   output logic ASYNC_RESET_O,
   output logic FETCH_START_O,
   output logic [23:0] FETCH_ADDR_O,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [15:0] REG_RDATA_O
);

   wrs_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic soft_r;
   logic filtered_reset_in_meta_r;
   logic filtered_reset_in_s_r;
   logic mode_meta_r;
   logic mode_s_r;
   logic [1:0] low_cnt_r;
   logic pd_r;
   logic bidir_en_r;
   logic init_pending_r;
   wrs_flags_t flags_r;
   logic transp_r;
   logic [1:0] tcnt_r;
   logic [15:0] config_r;
   logic fetch_start_r;
   logic [23:0] fetch_addr_r;
   logic flash_only_r;
   logic mode_pd_r;
   logic [15:0] rdata_r;

   logic hw_start;
   logic async_start;
   logic async_hit;
   logic soft_req;
   logic cmd_wr;
   logic exit_now;
   logic sample_done;
   logic boot_internal;
   logic pd_start;

   // Two-stage synchronisers; only the second stage is looked at
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         filtered_reset_in_meta_r <= 1'b1;
         filtered_reset_in_s_r <= 1'b1;
         mode_meta_r <= 1'b1;
         mode_s_r <= 1'b1;
      end else if (CE_I) begin
         filtered_reset_in_meta_r <= FILTERED_RESET_IN_I;
         filtered_reset_in_s_r <= filtered_reset_in_meta_r;
         mode_meta_r <= RESET_MODE_SENSE_PIN_I;
         mode_s_r <= mode_meta_r;
      end
   end

   // Consecutive low cycles of the filtered input, saturating
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         low_cnt_r <= 2'h0;
      end else if (CE_I) begin
         if (filtered_reset_in_s_r) begin
            low_cnt_r <= 2'h0;
         end else if (low_cnt_r != 2'h3) begin
            low_cnt_r <= low_cnt_r + 2'h1;
         end
      end
   end

   assign boot_internal = EXTERNAL_BOOT_SELECT_I;
   assign cmd_wr = REG_WR_I && (REG_ADDR_I == OFS_CMD);
   assign soft_req = WATCHDOG_RESET_I || (cmd_wr && REG_WDATA_I[CMD_SOFT_RESET_BIT]);
   // For hardware starts the mode pin only counts while the filtered input is low
   assign async_start = !filtered_reset_in_s_r && !mode_s_r;
   assign hw_start = !filtered_reset_in_s_r && mode_s_r && (low_cnt_r == ASSERT_LAST);
   assign async_hit = !soft_r && !filtered_reset_in_s_r && !mode_s_r;
   assign sample_done = (state_r == ST_SAMPLE) && (cnt_r == SAMPLE_LAST);
   assign exit_now = (state_r == ST_FLASH) && (!boot_internal || FLASH_INIT_DONE_I);
   assign pd_start = (state_r == ST_IDLE) && !async_start && bidir_en_r &&
                     (hw_start || (soft_req && mode_s_r));

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         soft_r <= 1'b0;
      end else if (CE_I) begin
         unique case (state_r)
            ST_IDLE: begin
               cnt_r <= '0;
               if (async_start) begin
                  state_r <= ST_ASYNC;
                  soft_r <= 1'b0;
               end else if (hw_start) begin
                  state_r <= ST_DETECT;
                  soft_r <= 1'b0;
               end else if (soft_req) begin
                  state_r <= ST_DETECT;
                  soft_r <= 1'b1;
               end
            end
            ST_DETECT: begin
               if (async_hit) begin
                  state_r <= ST_ASYNC;
               end else if (cnt_r == CANCEL_LAST) begin
                  state_r <= ST_SEQ;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            ST_SEQ: begin
               if (async_hit) begin
                  state_r <= ST_ASYNC;
               end else if (cnt_r == SEQ_LAST) begin
                  state_r <= ST_SAMPLE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            ST_SAMPLE: begin
               if (async_hit) begin
                  state_r <= ST_ASYNC;
               end else if (cnt_r == SAMPLE_LAST) begin
                  state_r <= filtered_reset_in_s_r ? ST_FLASH : ST_EXTEND;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            ST_EXTEND: begin
               if (async_hit) begin
                  state_r <= ST_ASYNC;
               end else if (filtered_reset_in_s_r) begin
                  state_r <= ST_FLASH;
               end
            end
            ST_ASYNC: begin
               // Stays asynchronous even if the mode pin recovers
               if (filtered_reset_in_s_r) begin
                  state_r <= ST_FLASH;
               end
            end
            ST_FLASH: begin
               if (exit_now) begin
                  state_r <= ST_IDLE;
                  soft_r <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               cnt_r <= '0;
               soft_r <= 1'b0;
            end
         endcase
      end
   end

   // Own pull-down on the reset pin, released at internal sequence end
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         pd_r <= 1'b0;
      end else if (CE_I) begin
         if (pd_start) begin
            pd_r <= 1'b1;
         end else if (state_r == ST_ASYNC || (state_r == ST_SEQ && cnt_r == SEQ_LAST)) begin
            pd_r <= 1'b0;
         end else if (soft_r && !mode_s_r) begin
            pd_r <= 1'b0;
         end
      end
   end

   // Exit clear wins; writes are refused outside the init window
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         bidir_en_r <= SYSCFG_RST[BIDIR_EN_BIT];
      end else if (CE_I) begin
         if (exit_now) begin
            bidir_en_r <= 1'b0;
         end else if (REG_WR_I && REG_ADDR_I == OFS_SYSCFG && init_pending_r && state_r == ST_IDLE) begin
            bidir_en_r <= REG_WDATA_I[BIDIR_EN_BIT];
         end
      end
   end

   // Reset output held until end of initialisation is commanded
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         init_pending_r <= 1'b1;
      end else if (CE_I) begin
         if (state_r != ST_IDLE) begin
            init_pending_r <= 1'b1;
         end else if (cmd_wr && REG_WDATA_I[CMD_END_INIT_BIT]) begin
            init_pending_r <= 1'b0;
         end
      end
   end

   // Status flags: hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge CLK_I) begin
      wrs_flags_t set_v;
      wrs_flags_t clr_v;
      set_v = FLAGS_RST;
      clr_v = FLAGS_RST;
      if (RESET_I) begin
         flags_r <= FLAGS_RST;
      end else if (CE_I) begin
         if (REG_WR_I && REG_ADDR_I == OFS_STATUS) begin
            clr_v = wrs_flags_t'(REG_WDATA_I[3:0]);
         end
         // Only a hardware reset can turn asynchronous; soft resets mask it
         set_v.async_rst = async_hit && (state_r != ST_ASYNC) &&
                           (state_r != ST_FLASH);
         set_v.soft_rst = (state_r == ST_IDLE) && !async_start && !hw_start && soft_req;
         set_v.short_rst = sample_done;
         set_v.long_rst = sample_done && !filtered_reset_in_s_r;
         flags_r <= (flags_r & ~clr_v) | set_v;
      end
   end

   // Clock option pins transparent through a long reset
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         transp_r <= 1'b0;
         tcnt_r <= 2'h0;
      end else if (CE_I) begin
         if (sample_done && !filtered_reset_in_s_r) begin
            transp_r <= 1'b1;
            tcnt_r <= 2'h0;
         end else if (transp_r && filtered_reset_in_s_r) begin
            if (tcnt_r == TRANSP_LAST) begin
               transp_r <= 1'b0;
            end
            tcnt_r <= tcnt_r + 2'h1;
         end else begin
            tcnt_r <= 2'h0;
         end
      end
   end

   // Exit: latch configuration and point the fetch at the start vector
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         config_r <= CONFIG_RST;
         fetch_start_r <= 1'b0;
         fetch_addr_r <= FETCH_START_ADDR;
      end else if (CE_I) begin
         fetch_start_r <= exit_now;
         if (exit_now) begin
            fetch_addr_r <= FETCH_START_ADDR;
            if (soft_r) begin
               config_r <= (config_r & ~(SOFT_LATCHED_MASK | SOFT_CLEARED_MASK)) |
                           (PORT0_I & SOFT_LATCHED_MASK) | SOFT_CLEARED_MASK;
            end else begin
               config_r <= PORT0_I;
            end
         end
      end
   end

   // Pulse too short for a system reset still resets the flash
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         flash_only_r <= 1'b0;
      end else if (CE_I) begin
         flash_only_r <= (state_r == ST_IDLE) && filtered_reset_in_s_r && (low_cnt_r != 2'h0) &&
                         (low_cnt_r < 2'(ASSERT_MIN_CYC));
      end
   end

   // Follows the raw pin, so an outside low counts as well as our own
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         mode_pd_r <= 1'b0;
      end else if (CE_I) begin
         mode_pd_r <= !RESET_IN_N_I || pd_r;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         rdata_r <= 16'h0000;
      end else if (CE_I) begin
         rdata_r <= 16'h0000;
         if (REG_RD_I) begin
            unique case (REG_ADDR_I)
               OFS_SYSCFG: rdata_r[BIDIR_EN_BIT] <= bidir_en_r;
               OFS_STATUS: rdata_r <= {11'h000, init_pending_r, flags_r};
               OFS_CONFIG: rdata_r <= config_r;
               default: rdata_r <= 16'h0000;
            endcase
         end
      end
   end

   // Open drain: the pin is only ever driven low
   assign RESET_IN_N_O = 1'b0;
   assign RESET_IN_N_OE_N_O = !pd_r;
   assign RESET_MODE_PULLDOWN_O = mode_pd_r;
   assign FLASH_INIT_REQ_O = (state_r == ST_FLASH) && boot_internal;
   assign FLASH_ONLY_RESET_O = flash_only_r;
   assign CONFIG_O = config_r;
   assign CLOCK_OPTION_PINS_TRANSPARENT_O = transp_r;
   assign RESET_OUT_N_O = !init_pending_r;
   assign CPU_RESET_O = (state_r != ST_IDLE);
   assign IO_TRISTATE_O = (state_r != ST_IDLE);
   assign BUS_ABORT_O = (state_r == ST_DETECT) || (state_r == ST_ASYNC);
   assign HOLD_CANCEL_O = (state_r == ST_DETECT) || (state_r == ST_ASYNC);
   assign STROBES_IDLE_O = (state_r != ST_IDLE);
   assign ASYNC_RESET_O = (state_r == ST_ASYNC);
   assign FETCH_START_O = fetch_start_r;
   assign FETCH_ADDR_O = fetch_addr_r;
   assign REG_RDATA_O = rdata_r;

endmodule

// *** wrs_props.sv ***
`timescale 1ns/1ps
module wrs_props
   import wrs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic RESET_IN_N_I,
   input wire logic RESET_IN_N_OE_N_O,
   input wire logic FILTERED_RESET_IN_I,
   input wire logic RESET_MODE_PULLDOWN_O,
   input wire logic EXTERNAL_BOOT_SELECT_I,
   input wire logic FLASH_INIT_REQ_O,
   input wire logic CLOCK_OPTION_PINS_TRANSPARENT_O,
   input wire logic RESET_OUT_N_O,
   input wire logic CPU_RESET_O,
   input wire logic IO_TRISTATE_O,
   input wire logic BUS_ABORT_O,
   input wire logic HOLD_CANCEL_O,
   input wire logic STROBES_IDLE_O,
   input wire logic ASYNC_RESET_O,
   input wire logic FETCH_START_O,
   input wire logic [23:0] FETCH_ADDR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   logic [9:0] cnt_r;
   // Saturates so a long extension cannot wrap back into a window
   always_ff @(posedge CLK_I) begin
      if (RESET_I || !CPU_RESET_O) begin
         cnt_r <= 10'h000;
      end else if (cnt_r != 10'h3FF) begin
         cnt_r <= cnt_r + 10'h001;
      end
   end
   a_out_low_reset: assert property (CPU_RESET_O && $past(CPU_RESET_O) |-> !RESET_OUT_N_O)
      else $error("reset output high during reset");
   a_pins_quiet: assert property (CPU_RESET_O |-> IO_TRISTATE_O && STROBES_IDLE_O)
      else $error("pins not quiet during reset");
   a_cancel_span: assert property ($rose(HOLD_CANCEL_O) && !ASYNC_RESET_O |->
      HOLD_CANCEL_O[*6] ##1 ((!HOLD_CANCEL_O && CPU_RESET_O) || ASYNC_RESET_O))
      else $error("cancel phase length wrong");
   a_pin_release: assert property ($rose(RESET_IN_N_OE_N_O) && CPU_RESET_O && !ASYNC_RESET_O |->
      cnt_r inside {[514:520]})
      else $error("pin pull-down released at wrong time");
   a_sample_time: assert property ($rose(CLOCK_OPTION_PINS_TRANSPARENT_O) |-> cnt_r inside {[520:524]})
      else $error("long sample at wrong time");
   a_async_quiet: assert property (ASYNC_RESET_O |-> BUS_ABORT_O && IO_TRISTATE_O && HOLD_CANCEL_O)
      else $error("buses not aborted in asynchronous reset");
   a_pulldown_scope: assert property (!RESET_IN_N_OE_N_O |-> CPU_RESET_O)
      else $error("pin pulled low outside reset");
   a_mode_pulldown: assert property (!RESET_IN_N_I |=> RESET_MODE_PULLDOWN_O)
      else $error("mode pull-down missing");
   a_async_sticky: assert property (ASYNC_RESET_O && !FILTERED_RESET_IN_I |=> ASYNC_RESET_O)
      else $error("asynchronous reset left early");
   a_flash_wait: assert property (FLASH_INIT_REQ_O |-> EXTERNAL_BOOT_SELECT_I && CPU_RESET_O)
      else $error("flash wait without internal boot");
   a_fetch_start: assert property ($fell(CPU_RESET_O) |-> ##[0:1] FETCH_START_O)
      else $error("no fetch start after exit");
   a_fetch_zero: assert property (FETCH_START_O |-> FETCH_ADDR_O == 24'h00_0000)
      else $error("fetch address not zero");
   c_async: cover property ($rose(ASYNC_RESET_O));
   c_long: cover property ($rose(CLOCK_OPTION_PINS_TRANSPARENT_O));
   c_flash: cover property ($rose(FLASH_INIT_REQ_O));
   c_release: cover property ($rose(RESET_IN_N_OE_N_O));
endmodule

bind wrs_sequencer wrs_props u_props (.*);

// *** wrs_ext_rst.sv ***
`timescale 1ns/1ps
module wrs_ext_rst (
   input wire logic clk_i,
   input wire logic press_i,
   input wire logic mode_low_i,
   input wire logic pin_out_i,
   input wire logic pin_oe_n_i,
   output logic pin_n_o,
   output logic filt_n_o,
   output logic mode_o
);
   // Pull-up on the wire; any party pulling low wins
   assign pin_n_o = !press_i && (pin_oe_n_i || pin_out_i);
   // One cycle of filter lag; real filters lag more
   always_ff @(posedge clk_i) begin
      filt_n_o <= pin_n_o;
   end
   // Large capacitor stays charged unless the bench discharges it
   assign mode_o = !mode_low_i;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import wrs_pkg::*;
   logic clk, rst, press, mode_low, wd, fdone, boot, rd, wr;
   logic pin_n, filt_n, mode, pin_out, oe_n, mpd, freq, fonly, transp, rout_n, cpu_rst, async_o, fstart;
   logic [3:0] addr;
   logic [15:0] wdat, p0, cfg, rdata, v;
   logic [23:0] faddr;
   int err_total, n_checks, n, bad;
   wrs_ext_rst u_ext (.clk_i(clk), .press_i(press), .mode_low_i(mode_low), .pin_out_i(pin_out),
      .pin_oe_n_i(oe_n), .pin_n_o(pin_n), .filt_n_o(filt_n), .mode_o(mode));
   wrs_sequencer uut (.CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .RESET_IN_N_I(pin_n), .RESET_IN_N_O(pin_out),
      .RESET_IN_N_OE_N_O(oe_n), .FILTERED_RESET_IN_I(filt_n), .RESET_MODE_SENSE_PIN_I(mode),
      .RESET_MODE_PULLDOWN_O(mpd), .EXTERNAL_BOOT_SELECT_I(boot), .WATCHDOG_RESET_I(wd),
      .FLASH_INIT_DONE_I(fdone), .FLASH_INIT_REQ_O(freq), .FLASH_ONLY_RESET_O(fonly), .PORT0_I(p0),
      .CONFIG_O(cfg), .CLOCK_OPTION_PINS_TRANSPARENT_O(transp), .RESET_OUT_N_O(rout_n), .CPU_RESET_O(cpu_rst),
      .IO_TRISTATE_O(), .BUS_ABORT_O(), .HOLD_CANCEL_O(), .STROBES_IDLE_O(), .ASYNC_RESET_O(async_o),
      .FETCH_START_O(fstart), .FETCH_ADDR_O(faddr), .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_RDATA_O(rdata));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic wait_exit();
      n = 0;
      while (fstart !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(faddr, 24'h00_0000);
      chk(cpu_rst, 24'h00_0000);
   endtask
   task automatic t_power();
      chk(rout_n, 24'h00_0000);
      chk(cfg, 24'h00_0000);
      wr_reg(OFS_SYSCFG, 16'h0008);
      rd_reg(OFS_SYSCFG, v);
      chk(v, 24'h00_0008);
      rd_reg(4'h7, v);
      chk(v, 24'h00_0000);
      rd_reg(OFS_STATUS, v);
      chk(v, 24'h00_0010);
   endtask
   task automatic t_short_bidir();
      p0 <= 16'h5A3C;
      press <= 1'b1;
      repeat (3) @(posedge clk);
      press <= 1'b0;
      n = 0;
      while (oe_n !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(oe_n, 24'h00_0000);
      n = 0;
      while (oe_n === 1'b0 && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk({23'h0, n >= 510 && n <= 518}, 24'h00_0001);
      wait_exit();
      chk(cfg, 24'h00_5A3C);
      rd_reg(OFS_STATUS, v);
      chk(v & 16'h001B, 24'h00_0012);
      rd_reg(OFS_SYSCFG, v);
      chk(v, 24'h00_0000);
      wr_reg(OFS_CMD, 16'h0002);
      @(posedge clk);
      chk(rout_n, 24'h00_0001);
      wr_reg(OFS_SYSCFG, 16'h0008);
      rd_reg(OFS_SYSCFG, v);
      chk(v, 24'h00_0000);
   endtask
   task automatic t_long_internal();
      boot <= 1'b1;
      p0 <= 16'hC3A5;
      press <= 1'b1;
      repeat (600) @(posedge clk);
      chk(transp, 24'h00_0001);
      chk(mpd, 24'h00_0001);
      chk(rout_n, 24'h00_0000);
      press <= 1'b0;
      repeat (8) @(posedge clk);
      chk(transp, 24'h00_0000);
      chk(freq, 24'h00_0001);
      fdone <= 1'b1;
      wait_exit();
      fdone <= 1'b0;
      boot <= 1'b0;
      chk(cfg, 24'h00_C3A5);
      rd_reg(OFS_STATUS, v);
      chk(v, 24'h00_0016);
      wr_reg(OFS_STATUS, 16'h000F);
      rd_reg(OFS_STATUS, v);
      chk(v, 24'h00_0010);
   endtask
   task automatic t_async_convert();
      press <= 1'b1;
      repeat (12) @(posedge clk);
      mode_low <= 1'b1;
      repeat (4) @(posedge clk);
      chk(async_o, 24'h00_0001);
      mode_low <= 1'b0;
      repeat (6) @(posedge clk);
      chk(async_o, 24'h00_0001);
      press <= 1'b0;
      wait_exit();
      rd_reg(OFS_STATUS, v);
      chk(v & 16'h0008, 24'h00_0008);
      wr_reg(OFS_STATUS, 16'h000F);
      // Mode pin low before the reset pin: asynchronous straight from idle
      mode_low <= 1'b1;
      repeat (3) @(posedge clk);
      press <= 1'b1;
      repeat (6) @(posedge clk);
      chk(async_o, 24'h00_0001);
      mode_low <= 1'b0;
      press <= 1'b0;
      wait_exit();
      rd_reg(OFS_STATUS, v);
      chk(v & 16'h000F, 24'h00_0008);
      wr_reg(OFS_STATUS, 16'h000F);
   endtask
   task automatic t_soft_and_watchdog();
      p0 <= 16'h3355;
      rd_reg(OFS_SYSCFG, v);
      wr_reg(OFS_SYSCFG, 16'h0008);
      @(posedge clk);
      wr_reg(OFS_CMD, 16'h0001);
      n = 0;
      while (oe_n !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(oe_n, 24'h00_0000);
      wait_exit();
      chk(cfg, (16'hC3A5 & 16'hE003) | (16'h3355 & 16'h1F00) | 16'h00FC);
      rd_reg(OFS_STATUS, v);
      chk(v & 16'h0009, 24'h00_0001);
      wr_reg(OFS_SYSCFG, 16'h0008);
      mode_low <= 1'b1;
      // Let the mode pin pass the synchroniser before the watchdog fires
      repeat (3) @(posedge clk);
      wd <= 1'b1;
      @(posedge clk);
      wd <= 1'b0;
      bad = 0;
      n = 0;
      while (fstart !== 1'b1 && n < 3000) begin
         @(posedge clk);
         if (oe_n !== 1'b1 || async_o !== 1'b0) bad++;
         n++;
      end
      chk(bad, 24'h00_0000);
      chk({23'h0, n > 500 && n < 600}, 24'h00_0001);
      mode_low <= 1'b0;
   endtask
   task automatic t_flash_only();
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
      n = 0;
      bad = 0;
      repeat (8) begin
         @(posedge clk);
         if (fonly === 1'b1) n++;
         if (cpu_rst !== 1'b0) bad++;
      end
      chk(n, 24'h00_0001);
      chk(bad, 24'h00_0000);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end
   initial begin
      err_total = 0;
      n_checks = 0;
      rst = 1'b1;
      {press, mode_low, wd, fdone, boot, rd, wr} = 7'h00;
      addr = 4'h0;
      wdat = 16'h0000;
      p0 = 16'h0000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_power();
      t_short_bidir();
      t_long_internal();
      t_async_convert();
      t_soft_and_watchdog();
      t_flash_only();
      close_out();
   end
endmodule
